/* logic/dual_scan_mono_lcd_interface.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lcd_regs.svh"
module dual_scan_mono_lcd_interface
    import lcd_pkg::*;
#(
    parameter int ROW_DOTS  = `ROW_DOTS,
    parameter int HALF_ROWS = `HALF_ROWS,
    parameter int CHIP_DOTS = `CHIP_DOTS
) (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rst_b,
    // link pins from the timing controller
    input  wire logic                         pixel_shift_clock,
    input  wire logic                         row_latch_pulse,
    input  wire logic                         scan_start,
    input  wire logic                         display_enable_in,
    input  wire logic [`NIBBLE_W-1:0]         upper_half_nibble,
    input  wire logic [`NIBBLE_W-1:0]         lower_half_nibble,
    // panel drive
    output logic [ROW_DOTS-1:0]               col_drive_upper,
    output logic [ROW_DOTS-1:0]               col_drive_lower,
    output logic [$clog2(HALF_ROWS)-1:0]      row_select,
    output logic                              frame_polarity,
    output logic [ROW_DOTS/CHIP_DOTS-1:0]     chip_select,
    output logic                              display_on
);
    localparam int WORDS     = ROW_DOTS / `WORD_W;
    localparam int CHIPS     = ROW_DOTS / CHIP_DOTS;
    localparam int CHIP_WRDS = CHIP_DOTS / `WORD_W;
    localparam int WCW       = $clog2(WORDS);
    localparam int RSW       = $clog2(HALF_ROWS);

    generate
        if (ROW_DOTS % CHIP_DOTS != 0) begin : g_bad_chips
            $error("row width is not a whole number of chips");
        end
        if (CHIP_DOTS % `WORD_W != 0) begin : g_bad_words
            $error("chip width is not a whole number of words");
        end
        if (HALF_ROWS < 2 || WORDS < 2) begin : g_bad_size
            $error("too few rows or words for the scan logic");
        end
        if (`NIBBLE_W * `NIBBLES_PER_WORD != `WORD_W ||
            `NIBBLES_PER_WORD != 4) begin : g_bad_packer
            // the packer counts four nibbles in a two-bit counter
            $error("a word must hold exactly four nibbles");
        end
        if ($bits(half_word_s) != 2 * `WORD_W) begin : g_bad_carrier
            $error("word carrier does not match the word width");
        end
    endgenerate

    // link side: nibble packing on the falling shift clock edge
    typedef struct packed {
        logic [1:0]  cnt;
        logic [15:0] acc_up;
        logic [15:0] acc_lo;
        half_word_s  word;
        logic        tgl;
    } link_s;

    // core side
    typedef struct packed {
        logic [3:0]          lat_sync;
        logic [2:0]          tgl_sync;
        logic [1:0]          scan_sync;
        logic [1:0]          de_sync;
        logic [WCW-1:0]      wcnt;
        logic [ROW_DOTS-1:0] row_up;
        logic [ROW_DOTS-1:0] row_lo;
        logic [ROW_DOTS-1:0] col_up;
        logic [ROW_DOTS-1:0] col_lo;
        logic [RSW-1:0]      row_sel;
        logic                polarity;
        logic [CHIPS-1:0]    chip_sel;
        logic                display_enable_in_on;
    } core_s;

    link_s      link_ff;
    link_s      nxt_link;
    core_s      core_ff;
    core_s      nxt_core;
    logic       word_evt;
    logic       lat_evt;
    logic       buf_out_valid;
    half_word_s buf_out_data;
    logic       buf_out_ready;

    function automatic logic [CHIPS-1:0] chip_of(input logic [WCW-1:0] w);
        logic [CHIPS-1:0] sel;
        sel = '0;
        sel[int'(w) / CHIP_WRDS] = 1'b1;
        return sel;
    endfunction : chip_of

    // newest nibble enters at the top, so the first one ends up lowest
    function automatic logic [`WORD_W-1:0] shift_in(
        input logic [`WORD_W-1:0]   acc,
        input logic [`NIBBLE_W-1:0] nib
    );
        return {nib, acc[`WORD_W-1:`NIBBLE_W]};
    endfunction : shift_in

    // drop one word into its slot of a row image
    function automatic logic [ROW_DOTS-1:0] put_word(
        input logic [ROW_DOTS-1:0] row,
        input logic [WCW-1:0]      w,
        input logic [`WORD_W-1:0]  d
    );
        logic [ROW_DOTS-1:0] res;
        res = row;
        res[int'(w) * `WORD_W +: `WORD_W] = d;
        return res;
    endfunction : put_word

    // scan line after a latch: home on scan start, wrap after the last row
    function automatic logic [RSW-1:0] next_row(
        input logic [RSW-1:0] cur,
        input logic           home
    );
        logic [RSW-1:0] res;
        if (home || int'(cur) == HALF_ROWS - 1) begin
            res = '0;
        end else begin
            res = cur + 1'b1;
        end
        return res;
    endfunction : next_row

    always_comb begin
        nxt_link        = link_ff;
        nxt_link.cnt    = link_ff.cnt + 2'h1;
        // bit 0 of each nibble, and the first nibble, land lowest
        nxt_link.acc_up = shift_in(link_ff.acc_up,
                                   upper_half_nibble);
        nxt_link.acc_lo = shift_in(link_ff.acc_lo,
                                   lower_half_nibble);
        if (link_ff.cnt == 2'h3) begin
            nxt_link.word.upper = nxt_link.acc_up;
            nxt_link.word.lower = nxt_link.acc_lo;
            nxt_link.tgl        = ~link_ff.tgl;
        end
    end

    always_ff @(negedge pixel_shift_clock or negedge rst_b) begin
        if (!rst_b) begin
            link_ff <= '0;
        end else begin
            link_ff <= nxt_link;
        end
    end

    // word held stable four shift clocks after its toggle
    assign word_evt      = core_ff.tgl_sync[2] ^ core_ff.tgl_sync[1];
    // latch fall seen one stage later than the word toggle so the row's last word lands first
    assign lat_evt       = core_ff.lat_sync[3] & ~core_ff.lat_sync[2];
    assign buf_out_ready = ~lat_evt;

    // a word that meets the latch waits a cycle here instead of being lost
    two_entry_buffer #(
        .W ($bits(half_word_s))
    ) u_word_buf (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (word_evt),
        .in_data   (link_ff.word),
        .in_ready  (),
        .out_valid (buf_out_valid),
        .out_data  (buf_out_data),
        .out_ready (buf_out_ready)
    );

    always_comb begin
        nxt_core           = core_ff;
        nxt_core.lat_sync  = {core_ff.lat_sync[2:0], row_latch_pulse};
        nxt_core.tgl_sync  = {core_ff.tgl_sync[1:0], link_ff.tgl};
        nxt_core.scan_sync = {core_ff.scan_sync[0], scan_start};
        nxt_core.de_sync   = {core_ff.de_sync[0], display_enable_in};
        nxt_core.display_enable_in_on   = core_ff.de_sync[1];
        if (buf_out_valid && buf_out_ready) begin
            nxt_core.row_up = put_word(core_ff.row_up, core_ff.wcnt,
                                       buf_out_data.upper);
            nxt_core.row_lo = put_word(core_ff.row_lo, core_ff.wcnt,
                                       buf_out_data.lower);
            if (int'(core_ff.wcnt) != WORDS - 1) begin
                nxt_core.wcnt     = core_ff.wcnt + 1'b1;
                nxt_core.chip_sel = chip_of(nxt_core.wcnt);
            end
        end
        if (lat_evt) begin
            // whole row moves to the columns at once; high bit drives on
            nxt_core.col_up   = core_ff.row_up;
            nxt_core.col_lo   = core_ff.row_lo;
            nxt_core.wcnt     = '0;
            nxt_core.chip_sel = chip_of('0);
            nxt_core.row_sel  = next_row(core_ff.row_sel,
                                         core_ff.scan_sync[1]);
            if (core_ff.scan_sync[1]) begin
                nxt_core.polarity = ~core_ff.polarity;
            end
        end
        if (!core_ff.de_sync[1]) begin
            // blanking; scanning and polarity keep running
            nxt_core.col_up = '0;
            nxt_core.col_lo = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_ff          <= '0;
            core_ff.row_sel  <= RSW'(`ROW_SEL_RST);
            core_ff.polarity <= `POLARITY_RST;
            core_ff.chip_sel <= CHIPS'(1);
        end else begin
            core_ff <= nxt_core;
        end
    end

    assign col_drive_upper = core_ff.col_up;
    assign col_drive_lower = core_ff.col_lo;
    assign row_select      = core_ff.row_sel;
    assign frame_polarity  = core_ff.polarity;
    assign chip_select     = core_ff.chip_sel;
    assign display_on      = core_ff.display_enable_in_on;
endmodule : dual_scan_mono_lcd_interface
`default_nettype wire

/* logic/lcd_pkg.sv */
package lcd_pkg;
    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] lower;
    } half_word_s;
endpackage : lcd_pkg

/* logic/lcd_regs.svh */
// Contract
// - two halves, 240 rows each, 1/240 duty
// - 4-bit nibbles per shift clock, left to right
// - upper and lower nibbles share one shift clock
// - latch pulse moves 640 dots to columns
// - latch fall captures row, advances scan line
// - scan start selects first row of both halves
// - drive polarity inverts every frame
// - chips enabled left to right, 20 clocks each
// - high bit means dot on, black
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH
`define ROW_DOTS          640
`define HALF_ROWS         240
`define CHIP_DOTS         80
`define NIBBLE_W          4
`define NIBBLES_PER_WORD  4
`define WORD_W            16
`define ROW_SEL_RST       0
`define POLARITY_RST      1'b0
`endif

/* logic/two_entry_buffer.sv */
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    // fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    generate
        if (W < 1) begin : g_bad_w
            $error("two_entry_buffer width must be positive");
        end
    endgenerate

    typedef struct packed {
        logic [W-1:0] head;
        logic [W-1:0] tail;
        logic [1:0]   count;
    } buf_s;

    buf_s buf_ff;
    buf_s nxt_buf;
    logic push;
    logic pop;

    assign in_ready  = (buf_ff.count != 2'h2);
    assign out_valid = (buf_ff.count != 2'h0);
    assign out_data  = buf_ff.head;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        nxt_buf = buf_ff;
        if (pop) begin
            nxt_buf.head = buf_ff.tail;
        end
        if (push) begin
            if (buf_ff.count == 2'h0 || (buf_ff.count == 2'h1 && pop)) begin
                nxt_buf.head = in_data;
            end else begin
                nxt_buf.tail = in_data;
            end
        end
        nxt_buf.count = buf_ff.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            buf_ff <= '0;
        end else begin
            buf_ff <= nxt_buf;
        end
    end
endmodule : two_entry_buffer
`default_nettype wire

/* verification/lcd_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module lcd_chk
    import lcd_pkg::*;
#(
    parameter int ROW_DOTS  = 640,
    parameter int HALF_ROWS = 240,
    parameter int CHIP_DOTS = 80
) (
    // clock, reset and pins
    input wire logic                          ref_clk,
    input wire logic                          rst_b,
    input wire logic                          row_latch_pulse,
    input wire logic                          scan_start,
    input wire logic                          display_enable_in,
    // panel drive
    input wire logic [ROW_DOTS-1:0]           col_drive_upper,
    input wire logic [ROW_DOTS-1:0]           col_drive_lower,
    input wire logic [$clog2(HALF_ROWS)-1:0]  row_select,
    input wire logic                          frame_polarity,
    input wire logic [ROW_DOTS/CHIP_DOTS-1:0] chip_select,
    input wire logic                          display_on
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    AST_CHIP_ONEHOT: assert property ($onehot(chip_select))
        else $error("chip select not one-hot");
    AST_CHIP_STEP: assert property ($changed(chip_select) |->
        chip_select == 8'h01 || chip_select == $past(chip_select) << 1)
        else $error("chip select skipped");
    AST_LATCH_CHIP: assert property ($fell(row_latch_pulse) |->
        ##7 chip_select == 8'h01)
        else $error("chip select not back to left");
    AST_ROW_STEP: assert property ($changed(row_select) |->
        row_select == 0 || row_select == $past(row_select) + 1'b1)
        else $error("row select jumped");
    AST_ROW_ADV: assert property (
        $fell(row_latch_pulse) && !scan_start |-> ##[4:7] $changed(row_select))
        else $error("row not advanced");
    AST_SCAN_HOME: assert property (
        $fell(row_latch_pulse) && scan_start |->
        ##[4:7] ($changed(frame_polarity) && row_select == 0))
        else $error("scan start not honoured");
    AST_BLANK: assert property (!display_enable_in [*8] |->
        col_drive_upper == '0 && col_drive_lower == '0)
        else $error("columns not blanked");
    AST_SHOW: assert property (
        display_enable_in [*5] |-> display_on)
        else $error("display not on");
endmodule : lcd_chk

bind dual_scan_mono_lcd_interface lcd_chk #(
    .ROW_DOTS(ROW_DOTS), .HALF_ROWS(HALF_ROWS), .CHIP_DOTS(CHIP_DOTS)
) lcd_chk_inst (
    .ref_clk, .rst_b, .row_latch_pulse, .scan_start, .display_enable_in,
    .col_drive_upper, .col_drive_lower, .row_select, .frame_polarity,
    .chip_select, .display_on
);
`default_nettype wire

/* verification/lcd_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
    // link pins
    output logic       pixel_shift_clock,
    output logic       row_latch_pulse,
    output logic       scan_start,
    output logic [3:0] upper_half_nibble,
    output logic [3:0] lower_half_nibble
);
    initial begin
        pixel_shift_clock = 1'b0;
        row_latch_pulse   = 1'b0;
        scan_start        = 1'b0;
        upper_half_nibble = 4'h0;
        lower_half_nibble = 4'h0;
    end
    // shift clock runs only inside a row; data inverts once hold is over
    task automatic send_row(input logic [639:0] up, input logic [639:0] lo,
                            input logic first);
        for (int k = 0; k < 160; k++) begin
            upper_half_nibble = up[4*k +: 4];
            lower_half_nibble = lo[4*k +: 4];
            #10 pixel_shift_clock = 1'b1;
            #62.5 pixel_shift_clock = 1'b0;
            #40 {upper_half_nibble, lower_half_nibble} =
                ~{upper_half_nibble, lower_half_nibble};
            #12.5;
        end
        // frames are cut to a few rows; frame period is untimed
        #5 scan_start = first;
        #55 row_latch_pulse = 1'b1;
        #100 row_latch_pulse = 1'b0;
        #100 scan_start = 1'b0;
    endtask : send_row
endmodule : lcd_host_model
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import lcd_pkg::*;
    logic         ref_clk, rst_b, display_enable_in;
    logic         pixel_shift_clock, row_latch_pulse, scan_start;
    logic [3:0]   upper_half_nibble, lower_half_nibble;
    logic [639:0] col_drive_upper, col_drive_lower;
    logic [7:0]   row_select, chip_select;
    logic         frame_polarity, display_on;
    int           n_mismatch = 0;
    int           cmp_count = 0;

    dual_scan_mono_lcd_interface dual_scan_mono_lcd_interface_inst (
        .ref_clk, .rst_b, .pixel_shift_clock, .row_latch_pulse, .scan_start,
        .display_enable_in, .upper_half_nibble, .lower_half_nibble,
        .col_drive_upper, .col_drive_lower, .row_select, .frame_polarity,
        .chip_select, .display_on);
    lcd_host_model lcd_host_model_inst (
        .pixel_shift_clock, .row_latch_pulse, .scan_start,
        .upper_half_nibble, .lower_half_nibble);

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    function automatic logic [639:0] pat(input int r);
        return {20{32'h0123abcd + 32'(r)}};
    endfunction : pat
    task automatic cmp_cols(input string nm, input logic [639:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_cols
    task automatic cmp_val(input string nm, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_val
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // send one row, then judge the outputs once the latch has landed
    task automatic row_chk(input int r, input logic first, en,
                           input logic [7:0] er, input logic ep);
        lcd_host_model_inst.send_row(pat(r), ~pat(r), first);
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp_cols("upper cols", en ? pat(r) : '0, col_drive_upper);
        cmp_cols("lower cols", en ? ~pat(r) : '0, col_drive_lower);
        cmp_val("row select", er, row_select);
        cmp_val("polarity", {7'h0, ep}, {7'h0, frame_polarity});
        cmp_val("chip select", 8'h01, chip_select);
        cmp_val("display on", {7'h0, en}, {7'h0, display_on});
    endtask : row_chk
    task automatic scen_reset;
        @(negedge ref_clk);
        cmp_cols("upper cols", '0, col_drive_upper);
        cmp_cols("lower cols", '0, col_drive_lower);
        cmp_val("row select", 8'h00, row_select);
        cmp_val("polarity", 8'h00, {7'h0, frame_polarity});
        cmp_val("chip select", 8'h01, chip_select);
        cmp_val("display on", 8'h00, {7'h0, display_on});
    endtask : scen_reset
    task automatic scen_frame_start;
        row_chk(0, 1'b1, 1'b1, 8'h00, 1'b1);
    endtask : scen_frame_start
    task automatic scen_rows;
        row_chk(1, 1'b0, 1'b1, 8'h01, 1'b1);
        row_chk(2, 1'b0, 1'b1, 8'h02, 1'b1);
    endtask : scen_rows
    task automatic scen_blank;
        @(posedge ref_clk) display_enable_in <= 1'b0;
        row_chk(3, 1'b0, 1'b0, 8'h03, 1'b1);
        @(posedge ref_clk) display_enable_in <= 1'b1;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp_val("display on", 8'h01, {7'h0, display_on});
        row_chk(4, 1'b0, 1'b1, 8'h04, 1'b1);
    endtask : scen_blank
    task automatic scen_new_frame;
        row_chk(5, 1'b1, 1'b1, 8'h00, 1'b0);
    endtask : scen_new_frame

    initial begin
        rst_b = 1'b0;
        display_enable_in = 1'b0;
        repeat (8) @(posedge ref_clk);
        scen_reset();
        @(posedge ref_clk);
        rst_b <= 1'b1;
        display_enable_in <= 1'b1;
        repeat (4) @(posedge ref_clk);
        scen_frame_start();
        scen_rows();
        scen_blank();
        scen_new_frame();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
